// >>> rtl/pbwc_map.svh
// Register offsets, field positions, reset values and cycle counts of the wait bridge
`ifndef PBWC_MAP_SVH
`define PBWC_MAP_SVH

// Register byte offsets on the bus
`define PBWC_WAIT_CTRL_OFS     8'h00
`define PBWC_STATUS_OFS        8'h04
`define PBWC_LAST_COUNT_OFS    8'h08

// Wait control fields
`define PBWC_WAIT_CTRL_RST     8'h77
`define PBWC_J_LSB             0
`define PBWC_J_MSB             3
`define PBWC_I_LSB             4
`define PBWC_I_MSB             7

// Status fields
`define PBWC_ST_HUNG_BIT       0
`define PBWC_ST_BUSY_BIT       1
`define PBWC_ST_B2B_BIT        2

// Cycle counts of one access
`define PBWC_BASE_CYCLES       8'd3
`define PBWC_K_FACTOR_BASE     8'd2
`define PBWC_K_PHASE_READ      3'd1
`define PBWC_K_SINGLE          3'd1
`define PBWC_K_WATCHDOG        3'd3
`define PBWC_K_TIMER_B2B       3'd3
`define PBWC_K_NONE            3'd0

`endif

// >>> rtl/pbwc_pkg.sv
// Types shared by the peripheral bus wait bridge
package pbwc_pkg;

  // Class of the peripheral register addressed by a CPU access
  typedef enum logic [2:0] {
    PBWC_CLS_PLAIN       = 3'h0,
    PBWC_CLS_TIMER_COUNT = 3'h1,
    PBWC_CLS_TIMER_CMP   = 3'h2,
    PBWC_CLS_WDT_MODE    = 3'h3,
    PBWC_CLS_CONV        = 3'h4,
    PBWC_CLS_SERIAL_ST   = 3'h5,
    PBWC_CLS_CRC_IN      = 3'h6
  } pbwc_class_t;

  typedef enum logic [4:0] {
    PBWC_ST_IDLE  = 5'b00001,
    PBWC_ST_LEAD  = 5'b00010,
    PBWC_ST_WAIT  = 5'b00100,
    PBWC_ST_TRAIL = 5'b01000,
    PBWC_ST_HUNG  = 5'b10000
  } pbwc_state_t;

endpackage

// >>> rtl/pbwc_wait_counter.sv
// Down counter that times the stretched part of a peripheral access
`timescale 1ns/1ns
`default_nettype none

module pbwc_wait_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             count_en,
  output logic                  last
);

  logic [WIDTH-1:0] remaining;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      remaining <= '0;
    end
    else if (load)
    begin
      remaining <= load_value;
    end
    else if (count_en && remaining != '0)
    begin
      remaining <= remaining - 1'b1;
    end
  end

  assign last = (remaining <= {{(WIDTH-1){1'b0}}, 1'b1});

endmodule

`default_nettype wire

// >>> rtl/pbwc_bridge.sv
// CPU to peripheral bus bridge with programmable and per-register wait states
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "pbwc_map.svh"

// Function
// - Reset loads wait control with 77h
// - Unwaited peripheral access takes three clocks
// - Wait control accessed only as whole byte
// - Access takes 3+i+j+(2+j)k clocks
// - Timer reads k 1/2; repeated compare writes 3/4
// - Watchdog mode write while running: k 3
// - Serial status reads, CRC writes: k 1
// - Stretch conflicting access, stall CPU meanwhile
// - Wait in prohibited clock hangs until reset
// - Conversion mode and result reads k 1/2
module pbwc_bridge #(
  parameter int CNT_W = 8
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Classic Wishbone register slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // CPU side access request
  input  wire logic                  cpu_req,
  input  wire logic                  cpu_we,
  input  wire pbwc_pkg::pbwc_class_t cpu_class,
  input  wire logic [15:0]           cpu_wdata,
  output logic      [15:0]           cpu_rdata,
  output logic                       cpu_ready,
  output logic                       cpu_ack,
  // Peripheral side
  output logic                       periph_req,
  output logic                       periph_we,
  output logic      [15:0]           periph_wdata,
  input  wire logic [15:0]           periph_rdata,
  input  wire logic                  periph_phase,
  input  wire logic                  watchdog_running,
  input  wire logic                  clock_prohibited
);

  import pbwc_pkg::*;

  // Extra wait count k for one access
  function automatic logic [2:0] extra_wait(
    input pbwc_class_t cls,
    input logic        we,
    input logic        phase,
    input logic        wdt_on,
    input logic        b2b
  );
    logic [2:0] k;
    k = `PBWC_K_NONE;
    unique case (cls)
      PBWC_CLS_TIMER_COUNT:
      begin
        if (!we)
        begin
          k = `PBWC_K_PHASE_READ + {2'b00, phase};
        end
      end
      PBWC_CLS_TIMER_CMP:
      begin
        if (!we)
        begin
          k = `PBWC_K_PHASE_READ + {2'b00, phase};
        end
        else if (b2b)
        begin
          k = `PBWC_K_TIMER_B2B + {2'b00, phase};
        end
      end
      PBWC_CLS_WDT_MODE:
      begin
        if (we && wdt_on)
        begin
          k = `PBWC_K_WATCHDOG;
        end
      end
      PBWC_CLS_CONV:
      begin
        if (!we)
        begin
          k = `PBWC_K_PHASE_READ + {2'b00, phase};
        end
      end
      PBWC_CLS_SERIAL_ST:
      begin
        if (!we)
        begin
          k = `PBWC_K_SINGLE;
        end
      end
      PBWC_CLS_CRC_IN:
      begin
        if (we)
        begin
          k = `PBWC_K_SINGLE;
        end
      end
      default:
      begin
        k = `PBWC_K_NONE;
      end
    endcase
    return k;
  endfunction

  // Wait clocks beyond the base three: i + j + (2 + j) * k
  function automatic logic [7:0] wait_clocks(
    input logic [3:0] i,
    input logic [3:0] j,
    input logic [2:0] k
  );
    logic [7:0] factor;
    factor = `PBWC_K_FACTOR_BASE + {4'h0, j};
    return 8'({4'h0, i} + {4'h0, j} + 8'(factor * {5'h00, k}));
  endfunction

  logic [7:0]  peripheral_wait_control;
  logic        hung;
  logic        b2b_armed;
  logic [7:0]  last_count;
  pbwc_state_t state;
  pbwc_state_t next_state;
  logic [7:0]  wait_len;
  logic [7:0]  next_count;
  logic        take;
  logic        hang_now;
  logic        wait_last;
  logic        wb_req;
  logic        sel_byte;

  assign take     = (state == PBWC_ST_IDLE) && cpu_req;
  assign wait_len = wait_clocks(peripheral_wait_control[`PBWC_I_MSB:`PBWC_I_LSB],
                                peripheral_wait_control[`PBWC_J_MSB:`PBWC_J_LSB],
                                extra_wait(cpu_class, cpu_we, periph_phase,
                                           watchdog_running, b2b_armed));
  assign next_count = `PBWC_BASE_CYCLES + wait_len;
  // Waited registers touched in a prohibited clock state lock the bus
  assign hang_now = take && clock_prohibited && (cpu_class != PBWC_CLS_PLAIN);

  pbwc_wait_counter #(
    .WIDTH (CNT_W)
  ) u_wait_counter (
    .clk        (clk),
    .reset      (reset),
    .load       (take),
    .load_value (CNT_W'(wait_len)),
    .count_en   (state == PBWC_ST_WAIT),
    .last       (wait_last)
  );

  // Access sequence: lead cycle, stretch, trail cycle, acknowledge
  always_comb
  begin
    next_state = state;
    unique case (state)
      PBWC_ST_IDLE:
      begin
        if (hang_now)
        begin
          next_state = PBWC_ST_HUNG;
        end
        else if (take)
        begin
          next_state = PBWC_ST_LEAD;
        end
      end
      PBWC_ST_LEAD:
      begin
        if (wait_last && last_count == `PBWC_BASE_CYCLES)
        begin
          next_state = PBWC_ST_TRAIL;
        end
        else
        begin
          next_state = PBWC_ST_WAIT;
        end
      end
      PBWC_ST_WAIT:
      begin
        if (wait_last)
        begin
          next_state = PBWC_ST_TRAIL;
        end
      end
      PBWC_ST_TRAIL:
      begin
        next_state = PBWC_ST_IDLE;
      end
      PBWC_ST_HUNG:
      begin
        next_state = PBWC_ST_HUNG;
      end
      default:
      begin
        next_state = PBWC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= PBWC_ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // CPU handshake, all from flip-flops
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cpu_ready <= 1'b1;
      cpu_ack   <= 1'b0;
    end
    else
    begin
      cpu_ready <= (next_state != PBWC_ST_WAIT) && (next_state != PBWC_ST_HUNG);
      cpu_ack   <= (state == PBWC_ST_TRAIL);
    end
  end

  // Peripheral request held for the whole stretched access
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      periph_req   <= 1'b0;
      periph_we    <= 1'b0;
      periph_wdata <= 16'h0000;
    end
    else if (take && !hang_now)
    begin
      periph_req   <= 1'b1;
      periph_we    <= cpu_we;
      periph_wdata <= cpu_wdata;
    end
    else if (state == PBWC_ST_TRAIL)
    begin
      periph_req <= 1'b0;
    end
  end

  // Read data is taken only after the stretch has let it settle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cpu_rdata <= 16'h0000;
    end
    else if (state == PBWC_ST_TRAIL && !periph_we)
    begin
      cpu_rdata <= periph_rdata;
    end
  end

  // Back-to-back timer compare writes
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      b2b_armed <= 1'b0;
    end
    else if (take)
    begin
      b2b_armed <= cpu_we && (cpu_class == PBWC_CLS_TIMER_CMP);
    end
  end

  // Length of the latest access, for software to see
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      last_count <= `PBWC_BASE_CYCLES;
    end
    else if (take)
    begin
      last_count <= next_count;
    end
  end

  // Lock flag only a reset clears
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hung <= 1'b0;
    end
    else if (hang_now)
    begin
      hung <= 1'b1;
    end
  end

  // Register bus: one-cycle acknowledge, unmapped reads give zero
  assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign sel_byte = (wb_sel_i == 4'h1);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      peripheral_wait_control <= `PBWC_WAIT_CTRL_RST;
    end
    else if (wb_req && wb_we_i && sel_byte && wb_adr_i == `PBWC_WAIT_CTRL_OFS)
    begin
      peripheral_wait_control <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (wb_req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        `PBWC_WAIT_CTRL_OFS:
        begin
          wb_dat_o <= sel_byte ? {24'h00_0000, peripheral_wait_control}
                               : 32'h0000_0000;
        end
        `PBWC_STATUS_OFS:
        begin
          wb_dat_o <= {29'h0000_0000, b2b_armed, (state != PBWC_ST_IDLE), hung};
        end
        `PBWC_LAST_COUNT_OFS:
        begin
          wb_dat_o <= {24'h00_0000, last_count};
        end
        default:
        begin
          wb_dat_o <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> testbench/pbwc_bridge_assertions.sv
// Port checker of the wait bridge
`timescale 1ns/1ns
`default_nettype none
module pbwc_bridge_assertions (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o,
  input wire logic                  cpu_req,
  input wire logic                  cpu_we,
  input wire pbwc_pkg::pbwc_class_t cpu_class,
  input wire logic                  cpu_ready,
  input wire logic                  cpu_ack,
  input wire logic                  periph_req,
  input wire logic                  periph_we,
  input wire logic                  clock_prohibited
);
  import pbwc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Idle bridge sees a request
  sequence s_take;
    cpu_req && cpu_ready && !periph_req && !cpu_ack;
  endsequence
  sequence s_hang_take;
    s_take ##0 clock_prohibited && cpu_class != PBWC_CLS_PLAIN;
  endsequence
  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("register ack late or long");
  property p_ack_pulse;
    cpu_ack |=> !cpu_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("access ack too long");
  property p_stall;
    !cpu_ready |-> !cpu_ack;
  endproperty
  a_stall: assert property (p_stall) else $error("ack while stalled");
  property p_lead;
    s_take ##0 !clock_prohibited |=> periph_req && cpu_ready;
  endproperty
  a_lead: assert property (p_lead) else $error("lead cycle wrong");
  property p_we;
    s_take ##0 !clock_prohibited |=> periph_we == $past(cpu_we);
  endproperty
  a_we: assert property (p_we) else $error("direction not passed on");
  property p_hold;
    periph_req && !cpu_ack && !clock_prohibited |=> periph_req || cpu_ack;
  endproperty
  a_hold: assert property (p_hold) else $error("peripheral request dropped early");
  property p_trail;
    $rose(cpu_ready) && !$past(reset) |=> cpu_ack;
  endproperty
  a_trail: assert property (p_trail) else $error("no ack after stall");
  property p_hang;
    s_hang_take |=> !cpu_ready [*8];
  endproperty
  a_hang: assert property (p_hang) else $error("hang released");
  property p_reset;
    disable iff (1'b0) reset |=> cpu_ready && !cpu_ack && !periph_req;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule
`default_nettype wire

// >>> testbench/pbwc_periph_model.sv
// One-register peripheral behind the bridge
`timescale 1ns/1ns
`default_nettype none
module pbwc_periph_model (
  input  wire logic        clk,
  input  wire logic        periph_req,
  input  wire logic        periph_we,
  input  wire logic [15:0] periph_wdata,
  output logic      [15:0] periph_rdata
);
  logic [15:0] store = 16'h0000;
  always @(posedge clk)
  begin
    if (periph_req && periph_we)
      store <= periph_wdata;
    // Outside a read the bus shows the inverse of the held value
    periph_rdata <= (periph_req && !periph_we) ? store : ~store;
  end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench of the wait bridge
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pbwc_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        cpu_req = 1'b0;
  logic        cpu_we = 1'b0;
  pbwc_class_t cpu_class = PBWC_CLS_PLAIN;
  logic [15:0] cpu_wdata = 16'h0;
  logic [15:0] cpu_rdata;
  logic        cpu_ready;
  logic        cpu_ack;
  logic        periph_req;
  logic        periph_we;
  logic [15:0] periph_wdata;
  logic [15:0] periph_rdata;
  logic        periph_phase = 1'b0;
  logic        watchdog_running = 1'b0;
  logic        clock_prohibited = 1'b0;
  logic [31:0] rd;
  logic [15:0] last_wr = 16'h0;
  int          wi;
  int          wj;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;

  pbwc_bridge i_dut (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_req(cpu_req), .cpu_we(cpu_we),
    .cpu_class(cpu_class), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_ready(cpu_ready), .cpu_ack(cpu_ack), .periph_req(periph_req),
    .periph_we(periph_we), .periph_wdata(periph_wdata), .periph_rdata(periph_rdata),
    .periph_phase(periph_phase), .watchdog_running(watchdog_running),
    .clock_prohibited(clock_prohibited));
  pbwc_periph_model i_periph (.clk(clk), .periph_req(periph_req), .periph_we(periph_we),
    .periph_wdata(periph_wdata), .periph_rdata(periph_rdata));

  always #2 clk = ~clk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    // Only the bench timeout ends a wait for the acknowledge
    do
    begin
      @(posedge clk);
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic set_wctl(input logic [7:0] v);
    wb(1'b1, 8'h00, 4'h1, {24'h0, v});
    wb(1'b0, 8'h00, 4'h1, 32'h0);
    chk("wait control", {24'h0, v}, rd);
    wi = v[7:4];
    wj = v[3:0];
  endtask

  task automatic cpu_acc(input logic we, input pbwc_class_t c, input logic ph,
                         input logic wd, input int k);
    int n;
    int w;
    n = 0;
    w = 0;
    cpu_req          <= 1'b1;
    cpu_we           <= we;
    cpu_class        <= c;
    periph_phase     <= ph;
    watchdog_running <= wd;
    clock_prohibited <= 1'b0;
    cpu_wdata        <= cpu_wdata + 16'h1357;
    @(posedge clk);
    cpu_req <= 1'b0;
    do
    begin
      @(posedge clk);
      n++;
      w += (cpu_ready === 1'b0);
    end
    while (cpu_ack !== 1'b1 && n < 400);
    chk("access cycles", 3 + wi + wj + (2 + wj) * k, n);
    chk("wait cycles", wi + wj + (2 + wj) * k, w);
    if (we)
      last_wr = cpu_wdata;
    else
      chk("read data", {16'h0, last_wr}, {16'h0, cpu_rdata});
  endtask

  task summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors++;
      summarize();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    wb(1'b0, 8'h00, 4'h1, 32'h0);
    chk("reset value", 32'h77, rd);
    wb(1'b1, 8'h00, 4'h3, 32'h0);
    wb(1'b0, 8'h00, 4'hf, 32'h0);
    chk("wide read", 32'h0, rd);
    wb(1'b0, 8'h00, 4'h1, 32'h0);
    chk("wide write", 32'h77, rd);
    wb(1'b0, 8'h0c, 4'h1, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test registers done");
    set_wctl(8'h00);
    cpu_acc(1'b0, PBWC_CLS_PLAIN, 1'b0, 1'b0, 0);
    cpu_acc(1'b0, PBWC_CLS_SERIAL_ST, 1'b1, 1'b0, 1);
    set_wctl(8'h01);
    cpu_acc(1'b1, PBWC_CLS_PLAIN, 1'b0, 1'b0, 0);
    set_wctl(8'h11);
    cpu_acc(1'b0, PBWC_CLS_TIMER_COUNT, 1'b0, 1'b0, 1);
    cpu_acc(1'b0, PBWC_CLS_TIMER_COUNT, 1'b1, 1'b0, 2);
    cpu_acc(1'b1, PBWC_CLS_TIMER_CMP, 1'b1, 1'b0, 0);
    cpu_acc(1'b1, PBWC_CLS_TIMER_CMP, 1'b0, 1'b0, 3);
    cpu_acc(1'b1, PBWC_CLS_TIMER_CMP, 1'b1, 1'b0, 4);
    cpu_acc(1'b0, PBWC_CLS_TIMER_CMP, 1'b1, 1'b0, 2);
    cpu_acc(1'b1, PBWC_CLS_WDT_MODE, 1'b0, 1'b1, 3);
    cpu_acc(1'b1, PBWC_CLS_WDT_MODE, 1'b0, 1'b0, 0);
    cpu_acc(1'b0, PBWC_CLS_CONV, 1'b0, 1'b0, 1);
    cpu_acc(1'b0, PBWC_CLS_CONV, 1'b1, 1'b0, 2);
    cpu_acc(1'b1, PBWC_CLS_CRC_IN, 1'b1, 1'b0, 1);
    cpu_acc(1'b0, PBWC_CLS_SERIAL_ST, 1'b0, 1'b0, 1);
    wb(1'b0, 8'h08, 4'h1, 32'h0);
    chk("last count", 3 + wi + wj + (2 + wj), rd);
    $display("test waits done");
    clock_prohibited <= 1'b1;
    cpu_req          <= 1'b1;
    cpu_class        <= PBWC_CLS_CRC_IN;
    @(posedge clk);
    cpu_req <= 1'b0;
    repeat (30) @(posedge clk);
    chk("hung ready", 32'h0, {31'h0, cpu_ready});
    wb(1'b0, 8'h04, 4'hf, 32'h0);
    chk("hung status", 32'h3, rd);
    reset            <= 1'b1;
    clock_prohibited <= 1'b0;
    @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("ready after reset", 32'h1, {31'h0, cpu_ready});
    wb(1'b0, 8'h00, 4'h1, 32'h0);
    chk("reset value again", 32'h77, rd);
    wb(1'b0, 8'h04, 4'h1, 32'h0);
    chk("status after reset", 32'h0, rd);
    $display("test hang done");
    summarize();
  end
endmodule
bind pbwc_bridge pbwc_bridge_assertions i_chk (
  .clk              (clk),
  .reset            (reset),
  .wb_cyc_i         (wb_cyc_i),
  .wb_stb_i         (wb_stb_i),
  .wb_ack_o         (wb_ack_o),
  .cpu_req          (cpu_req),
  .cpu_we           (cpu_we),
  .cpu_class        (cpu_class),
  .cpu_ready        (cpu_ready),
  .cpu_ack          (cpu_ack),
  .periph_req       (periph_req),
  .periph_we        (periph_we),
  .clock_prohibited (clock_prohibited)
);
`default_nettype wire
